// [hdl/isc_config_regs.sv]
/*
 * Configuration register bank of the inductance-to-digital converter: register slave,
 * field decode, shutdown gating, buffered loss threshold and the conversion period counter.
 * Assumes an Avalon-MM master that holds its request until waitrequest is low, and a
 * measurement core that supplies a pulse at three times the sensor frequency.
 */
`timescale 1ns/1ns

// How it works
// - Frequency code gives 8 MHz over (16-code)
// - Response code selects 192 to 6144 periods
// - Response code resets to 384 periods code
// - Conversion spans periods of triple sensor clock
// - Response time skips high-resolution inductance path
// - Shutdown request needs enable; enable resets off
// - Inductance-only drive disables loss measurement
// - Low threshold byte writable during conversions
// - Low byte buffered until high byte written
module isc_config_regs import isc_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire isc_avs_req_type avs_req,
	output logic avs_waitrequest,
	output logic [31:0] avs_readdata,
	// Measurement core
	input wire logic active_mode,
	input wire logic triple_sensor_tick,
	output logic conv_done,
	output logic [ISC_PERIOD_W-1:0] periods_per_conversion,
	output logic periods_select_invalid,
	output logic [3:0] lowest_sensor_freq_code,
	output logic [ISC_FREQ_W-1:0] lowest_sensor_freq_khz,
	output logic hires_timing_independent,
	// Drive and power control
	output logic inductance_only_drive,
	output logic loss_measure_enable,
	output logic shutdown_active,
	output logic [15:0] loss_high_limit
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic [ISC_FREQ_W-1:0] freq_khz_of(input logic [3:0] code);
		int div;
		div = ISC_FREQ_STEPS - int'(code);
		return ISC_FREQ_W'(ISC_FREQ_REF_KHZ / div);
	endfunction

	// Reserved codes decode to zero periods, which the counter treats as halt
	function automatic logic [ISC_PERIOD_W-1:0] periods_of(input logic [2:0] sel);
		logic [ISC_PERIOD_W-1:0] base;
		base = ISC_PERIOD_W'(ISC_PERIOD_BASE);
		if (sel < ISC_RESP_FIRST_VALID) begin
			return '0;
		end
		return base << sel;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	isc_state_type s_q, s_d;
	logic [3:0] idx;
	logic aligned;
	logic req;
	logic wr_fire;
	logic [7:0] wbyte;
	logic [ISC_PERIOD_W-1:0] periods;

	assign idx = avs_req.address[ISC_ADDR_W-1:2];
	assign aligned = (avs_req.address[1:0] == 2'h0);
	assign req = avs_req.read | avs_req.write;
	assign wbyte = avs_req.writedata[7:0];
	// Writes land only in the cycle the request is acknowledged
	assign wr_fire = avs_req.write & s_q.ack & avs_req.byteenable[0] & aligned;
	assign periods = periods_of(s_q.digital_configuration[ISC_RESP_MSB:ISC_RESP_LSB]);

	// One wait state lets read data come from a flip-flop
	assign avs_waitrequest = req & ~s_q.ack;
	assign avs_readdata = s_q.rdata;

	always_comb begin
		s_d = s_q;
		s_d.conv_done = 1'b0;
		s_d.ack = req & ~s_q.ack;
		// Read data is captured in the waiting cycle so it stands at the answer
		if (avs_req.read & ~s_q.ack) begin
			s_d.rdata = '0;
			if (aligned) begin
				case (idx)
					ISC_IDX_DIGITAL_CONFIGURATION: s_d.rdata[7:0] = s_q.digital_configuration;
					ISC_IDX_ALT_CONF: s_d.rdata[7:0] = s_q.alt_conf;
					ISC_IDX_LOSS_HI_LSB: s_d.rdata[7:0] = s_q.lo_buf;
					ISC_IDX_LOSS_HI_MSB: s_d.rdata[7:0] = s_q.loss_limit[15:8];
					ISC_IDX_SHUTDOWN: s_d.rdata[7:0] = s_q.shutdown;
					default: s_d.rdata = '0;
				endcase
			end
		end
		if (wr_fire) begin
			case (idx)
				ISC_IDX_DIGITAL_CONFIGURATION: s_d.digital_configuration = wbyte;
				ISC_IDX_ALT_CONF: s_d.alt_conf = wbyte;
				// No active-mode gate: threshold may change mid-conversion
				ISC_IDX_LOSS_HI_LSB: s_d.lo_buf = wbyte;
				// High byte write commits the buffered low byte at the same edge
				ISC_IDX_LOSS_HI_MSB: s_d.loss_limit = {wbyte, s_q.lo_buf};
				ISC_IDX_SHUTDOWN: s_d.shutdown = wbyte;
				default: s_d.shutdown = s_q.shutdown;
			endcase
		end
		// Period counter runs on the triple-rate tick, so a count of N ends after N/(3f)
		case (s_q.conv_state)
			ISC_CONV_IDLE: begin
				s_d.conv_cnt = '0;
				if (active_mode && periods != '0) begin
					s_d.conv_state = ISC_CONV_RUN;
				end
			end
			ISC_CONV_RUN: begin
				if (!active_mode || periods == '0) begin
					s_d.conv_state = ISC_CONV_IDLE;
					s_d.conv_cnt = '0;
				end else if (triple_sensor_tick) begin
					if (s_q.conv_cnt >= periods - 1'b1) begin
						s_d.conv_cnt = '0;
						s_d.conv_done = 1'b1;
					end else begin
						s_d.conv_cnt = s_q.conv_cnt + 1'b1;
					end
				end
			end
			default: s_d.conv_state = ISC_CONV_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		// Constants only, so reset never depends on the bus
		if (!rst_n) begin
			s_q.digital_configuration <= ISC_DIGITAL_CONFIGURATION_RST;
			s_q.alt_conf <= ISC_ALT_CONF_RST;
			s_q.lo_buf <= ISC_LOSS_HI_RST;
			s_q.loss_limit <= {ISC_LOSS_HI_RST, ISC_LOSS_HI_RST};
			s_q.shutdown <= ISC_SHUTDOWN_RST;
			s_q.ack <= 1'b0;
			s_q.rdata <= '0;
			s_q.conv_state <= ISC_CONV_IDLE;
			s_q.conv_cnt <= '0;
			s_q.conv_done <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Field decode outputs
	// ----------------------------------------------------------------
	assign lowest_sensor_freq_code = s_q.digital_configuration[ISC_FREQ_MSB:ISC_FREQ_LSB];
	// Integer kHz, rounded down; fractional frequencies lose their tail
	assign lowest_sensor_freq_khz = freq_khz_of(lowest_sensor_freq_code);
	assign periods_per_conversion = periods;
	// Reserved codes stall conversions instead of guessing a length
	assign periods_select_invalid = (periods == '0);
	// High-resolution path keeps its own timing; this counter never feeds it
	assign hires_timing_independent = 1'b1;
	assign conv_done = s_q.conv_done;
	assign inductance_only_drive = s_q.alt_conf[ISC_L_ONLY_BIT];
	assign loss_measure_enable = ~s_q.alt_conf[ISC_L_ONLY_BIT];
	// Either the request or the enable alone is inert
	assign shutdown_active = s_q.shutdown[ISC_SHUT_REQ_BIT] & s_q.alt_conf[ISC_SHUT_EN_BIT];
	assign loss_high_limit = s_q.loss_limit;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Bus inputs also reach consequents, through avs_waitrequest and $past(wbyte)

	chk_freq_decode: assert property (
		(lowest_sensor_freq_code == 4'h0 |-> lowest_sensor_freq_khz == 14'd500) and
		(lowest_sensor_freq_code == 4'h8 |-> lowest_sensor_freq_khz == 14'd1000) and
		(lowest_sensor_freq_code == 4'hc |-> lowest_sensor_freq_khz == 14'd2000) and
		(lowest_sensor_freq_code == 4'hf |-> lowest_sensor_freq_khz == 14'd8000))
		else $error("minimum frequency decode wrong");

	chk_period_decode: assert property (
		(s_q.digital_configuration[2:0] == 3'h2 |-> periods == 13'd192) and
		(s_q.digital_configuration[2:0] == 3'h3 |-> periods == 13'd384) and
		(s_q.digital_configuration[2:0] == 3'h4 |-> periods == 13'd768) and
		(s_q.digital_configuration[2:0] == 3'h7 |-> periods == 13'd6144) and
		(s_q.digital_configuration[2:0] == 3'h5 |-> periods == 13'd1536) and
		(s_q.digital_configuration[2:0] == 3'h6 |-> periods == 13'd3072))
		else $error("period count decode wrong");

	chk_reset_resp: assert property (
		$rose(rst_n) |-> s_q.digital_configuration[2:0] == 3'h3 && periods == 13'd384)
		else $error("response field not at reset code");

	chk_conv_length: assert property (
		s_q.conv_state == ISC_CONV_RUN && triple_sensor_tick && s_q.conv_cnt == periods - 1'b1 &&
		active_mode && periods != '0 |=> conv_done && s_q.conv_cnt == '0)
		else $error("conversion did not end at period count");

	chk_no_early_done: assert property (
		conv_done |-> $past(s_q.conv_cnt) == periods - 1'b1)
		else $error("conversion ended early");

	chk_shutdown_gate: assert property (
		(!s_q.alt_conf[1] |-> !shutdown_active) and
		(s_q.alt_conf[1] && s_q.shutdown[1] |-> shutdown_active))
		else $error("shutdown took effect without enable");

	chk_lonly_drive: assert property (
		(inductance_only_drive |-> !loss_measure_enable) and
		(!inductance_only_drive |-> loss_measure_enable))
		else $error("loss measurement enabled in inductance-only mode");

	chk_low_buffered: assert property (
		wr_fire && idx == ISC_IDX_LOSS_HI_LSB |=> loss_high_limit == $past(loss_high_limit))
		else $error("low byte write changed threshold");

	chk_high_applies: assert property (
		wr_fire && idx == ISC_IDX_LOSS_HI_MSB |=> loss_high_limit == {$past(wbyte), $past(s_q.lo_buf)})
		else $error("high byte write did not apply threshold");

	chk_bus_answer: assert property (
		req && !s_q.ack |=> !avs_waitrequest)
		else $error("bus answer not after one wait state");

	chk_bus_wait: assert property (
		req && !s_q.ack |-> avs_waitrequest)
		else $error("request answered without a wait state");

	chk_read_stands: assert property (
		!(avs_req.read && !s_q.ack) |=> $stable(avs_readdata))
		else $error("read data changed without a new read");

	chk_low_readback: assert property (
		avs_req.read && !s_q.ack && aligned && idx == ISC_IDX_LOSS_HI_LSB |=>
		avs_readdata == {24'h0, $past(s_q.lo_buf)})
		else $error("buffered low byte not read back");

	chk_high_readback: assert property (
		avs_req.read && !s_q.ack && aligned && idx == ISC_IDX_LOSS_HI_MSB |=>
		avs_readdata == {24'h0, loss_high_limit[15:8]})
		else $error("applied high byte not read back");

	chk_unmapped_read: assert property (
		avs_req.read && !s_q.ack && (!aligned || idx > ISC_IDX_SHUTDOWN) |=> avs_readdata == 32'h0)
		else $error("unmapped read returned data");

	chk_dig_write: assert property (
		wr_fire && idx == ISC_IDX_DIGITAL_CONFIGURATION |=> s_q.digital_configuration == $past(wbyte))
		else $error("digital configuration write lost");

	chk_alt_write: assert property (
		wr_fire && idx == ISC_IDX_ALT_CONF |=> s_q.alt_conf == $past(wbyte))
		else $error("alternate configuration write lost");

	chk_shutdown_write: assert property (
		wr_fire && idx == ISC_IDX_SHUTDOWN |=> s_q.shutdown == $past(wbyte))
		else $error("shutdown request write lost");

	chk_low_active: assert property (
		wr_fire && idx == ISC_IDX_LOSS_HI_LSB && active_mode |=> s_q.lo_buf == $past(wbyte))
		else $error("low byte write refused during conversion");

	chk_reset_fields: assert property (
		$rose(rst_n) |-> s_q.alt_conf == ISC_ALT_CONF_RST && !shutdown_active && loss_measure_enable)
		else $error("alternate fields not at reset values");

	chk_hires_free: assert property (
		hires_timing_independent)
		else $error("high-resolution timing tied to response field");

	chk_idle_quiet: assert property (
		s_q.conv_state == ISC_CONV_IDLE |-> s_q.conv_cnt == '0 && !conv_done)
		else $error("idle counter not cleared");

	chk_done_pulse: assert property (
		conv_done |=> !conv_done)
		else $error("conversion done held over one cycle");

	// ----------------------------------------------------------------
	// Coverage of the main scenarios
	// ----------------------------------------------------------------
	cov_conv_done: cover property (conv_done);
	cov_limit_update: cover property (wr_fire && idx == ISC_IDX_LOSS_HI_MSB && active_mode);
	cov_shutdown: cover property ($rose(shutdown_active));
	cov_lonly: cover property ($rose(inductance_only_drive));
	cov_low_active: cover property (wr_fire && idx == ISC_IDX_LOSS_HI_LSB && active_mode);

endmodule // isc_config_regs

// [hdl/isc_pkg.sv]
/*
 * Shared constants and carrier types for the inductive sense configuration register bank.
 * Assumes an Avalon-MM master with byte addressing and one aligned 32-bit word per register.
 */
package isc_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [3:0] ISC_IDX_DIGITAL_CONFIGURATION = 4'h4;
	localparam logic [3:0] ISC_IDX_ALT_CONF = 4'h5;
	localparam logic [3:0] ISC_IDX_LOSS_HI_LSB = 4'h6;
	localparam logic [3:0] ISC_IDX_LOSS_HI_MSB = 4'h7;
	localparam logic [3:0] ISC_IDX_SHUTDOWN = 4'hb;
	localparam int ISC_ADDR_W = 6;

	// ----------------------------------------------------------------
	// Reset values and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0] ISC_DIGITAL_CONFIGURATION_RST = 8'h03;
	localparam logic [7:0] ISC_ALT_CONF_RST = 8'h00;
	localparam logic [7:0] ISC_LOSS_HI_RST = 8'h00;
	localparam logic [7:0] ISC_SHUTDOWN_RST = 8'h00;
	localparam int ISC_FREQ_MSB = 7;
	localparam int ISC_FREQ_LSB = 4;
	localparam int ISC_RESP_MSB = 2;
	localparam int ISC_RESP_LSB = 0;
	localparam int ISC_SHUT_EN_BIT = 1;
	localparam int ISC_L_ONLY_BIT = 0;
	localparam int ISC_SHUT_REQ_BIT = 1;

	// ----------------------------------------------------------------
	// Frequency and conversion timing
	// ----------------------------------------------------------------
	localparam int ISC_FREQ_REF_KHZ = 8000;
	localparam int ISC_FREQ_STEPS = 16;
	localparam int ISC_PERIOD_BASE = 48;
	localparam logic [2:0] ISC_RESP_FIRST_VALID = 3'h2;
	localparam int ISC_PERIOD_W = 13;
	localparam int ISC_FREQ_W = 14;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic {ISC_CONV_IDLE, ISC_CONV_RUN} isc_conv_state_type;

	typedef struct packed {
		logic read;
		logic write;
		logic [ISC_ADDR_W-1:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} isc_avs_req_type;

	typedef struct packed {
		logic [7:0] digital_configuration;
		logic [7:0] alt_conf;
		logic [7:0] lo_buf;
		logic [15:0] loss_limit;
		logic [7:0] shutdown;
		logic ack;
		logic [31:0] rdata;
		isc_conv_state_type conv_state;
		logic [ISC_PERIOD_W-1:0] conv_cnt;
		logic conv_done;
	} isc_state_type;

endpackage

// [testbench/isc_config_regs_tb.sv]
/*
 * Self-checking bench for the configuration register bank: register bus, field decode,
 * shutdown gating, buffered threshold and conversion counting.
 * Assumes the package constants and one wait state per Avalon-MM request.
 */
`timescale 1ns/1ns
module isc_config_regs_tb import isc_pkg::*;;
	logic clk, rst_n, active_mode, triple_sensor_tick, conv_done, periods_select_invalid;
	logic hires_timing_independent, inductance_only_drive, loss_measure_enable, shutdown_active;
	logic avs_waitrequest;
	logic [31:0] avs_readdata;
	logic [ISC_PERIOD_W-1:0] periods_per_conversion;
	logic [3:0] lowest_sensor_freq_code;
	logic [ISC_FREQ_W-1:0] lowest_sensor_freq_khz;
	logic [15:0] loss_high_limit, rnd, lim;
	isc_avs_req_type req;
	logic [31:0] exp_q[$];
	int failures = 0, cmp_count = 0, dones = 0;

	isc_config_regs dut_u (.clk(clk), .rst_n(rst_n), .avs_req(req), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .active_mode(active_mode), .triple_sensor_tick(triple_sensor_tick),
		.conv_done(conv_done), .periods_per_conversion(periods_per_conversion),
		.periods_select_invalid(periods_select_invalid), .lowest_sensor_freq_code(lowest_sensor_freq_code),
		.lowest_sensor_freq_khz(lowest_sensor_freq_khz), .hires_timing_independent(hires_timing_independent),
		.inductance_only_drive(inductance_only_drive), .loss_measure_enable(loss_measure_enable),
		.shutdown_active(shutdown_active), .loss_high_limit(loss_high_limit));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Waits for waitrequest low, sampled at the edge before the slave's own update lands
	task automatic bus(input logic rd, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		req.read <= rd;
		req.write <= !rd;
		req.address <= a;
		req.byteenable <= 4'h1;
		req.writedata <= {24'h0, d};
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b0, a, d);
		@(posedge clk);
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(1'b1, a, 8'h00);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk) triple_sensor_tick <= 1'b1;
			@(posedge clk) triple_sensor_tick <= 1'b0;
			@(posedge clk);
		end
		repeat (3) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// Clock, monitor, watchdog
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Read answers are compared against the oldest queued note
	always @(posedge clk) begin
		if (rst_n && req.read && avs_waitrequest === 1'b0) begin
			if (exp_q.size() == 0)
				check(avs_readdata, 32'hdead_beef);
			else
				check(avs_readdata, exp_q.pop_front());
		end
		if (conv_done === 1'b1)
			dones++;
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		finish_test();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		active_mode = 1'b0;
		triple_sensor_tick = 1'b0;
		req = '0;
		rnd = 16'd29028;
		lim = 16'h0000;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		rd(6'h10, 8'h03);
		rd(6'h14, 8'h00);
		rd(6'h18, 8'h00);
		rd(6'h3c, 8'h00);
		check(32'(periods_per_conversion), 32'd384);
		check(32'(hires_timing_independent), 32'd1);
		$display("test reset done");
		for (int c = 0; c < 16; c++) begin
			wr(6'h10, {c[3:0], 4'h3});
			check(32'(lowest_sensor_freq_code), 32'(c));
			check(32'(lowest_sensor_freq_khz), 32'(8000 / (16 - c)));
		end
		$display("test frequency done");
		// Codes zero and one are reserved, so the host never writes them
		for (int r = 2; r < 8; r++) begin
			wr(6'h10, {5'h0, r[2:0]});
			check(32'(periods_per_conversion), 32'd192 << (r - 2));
			check(32'(periods_select_invalid), 32'd0);
		end
		$display("test response done");
		wr(6'h2c, 8'h02);
		check(32'(shutdown_active), 32'd0);
		wr(6'h14, 8'h02);
		check(32'(shutdown_active), 32'd1);
		wr(6'h14, 8'h01);
		check(32'({inductance_only_drive, loss_measure_enable, shutdown_active}), 32'h4);
		rd(6'h14, 8'h01);
		wr(6'h14, 8'h00);
		check(32'(loss_measure_enable), 32'd1);
		$display("test alternate done");
		active_mode <= 1'b1;
		repeat (2) begin
			rnd = lfsr(lfsr(rnd));
			wr(6'h18, rnd[7:0]);
			check(32'(loss_high_limit), 32'(lim));
			rd(6'h18, rnd[7:0]);
			wr(6'h1c, rnd[15:8]);
			lim = rnd;
			check(32'(loss_high_limit), 32'(lim));
			rd(6'h1c, rnd[15:8]);
		end
		$display("test threshold done");
		wr(6'h10, 8'h02);
		dones = 0;
		ticks(191);
		check(32'(dones), 32'd0);
		ticks(1);
		check(32'(dones), 32'd1);
		// Leaving active mode parks the counter, so later ticks finish nothing
		active_mode <= 1'b0;
		ticks(200);
		check(32'(dones), 32'd1);
		$display("test conversion done");
		finish_test();
	end
endmodule // isc_config_regs_tb
